// ### ccc_pkg.sv
// Package: register map and constants of the channel control block
package ccc_pkg;
   // Register bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Control registers that sit outside the control window
   localparam logic [7:0] OFF_CHANNEL_MODE     = 8'h80;
   localparam logic [7:0] OFF_CH7_MASK         = 8'h82;
   localparam logic [7:0] OFF_CH7_DATA         = 8'h83;
   localparam logic [7:0] OFF_COUNT_HI         = 8'h84;
   localparam logic [7:0] OFF_COUNT_LO         = 8'h85;
   localparam logic [7:0] OFF_SYS_CTRL         = 8'h86;
   localparam logic [7:0] OFF_OUT_ACTION_UPPER = 8'h88;
   localparam logic [7:0] OFF_OUT_ACTION_LOWER = 8'h89;
   // Documented control and flag registers
   localparam logic [7:0] OFF_EDGE_UPPER       = 8'h8a;
   localparam logic [7:0] OFF_EDGE_LOWER       = 8'h8b;
   localparam logic [7:0] OFF_CH_IRQ_MASK      = 8'h8c;
   localparam logic [7:0] OFF_OVF_MASK_PRE     = 8'h8d;
   localparam logic [7:0] OFF_CH_FLAGS         = 8'h8e;
   localparam logic [7:0] OFF_OVF_FLAGS        = 8'h8f;
   // Channel value registers, two bytes per channel
   localparam logic [7:0] OFF_CHAN_BASE        = 8'h90;
   localparam logic [7:0] OFF_CHAN_LAST        = 8'h9f;
   // Flag mode and overwrite control
   localparam logic [7:0] OFF_OVERWRITE_CTRL   = 8'haa;
   localparam logic [7:0] OFF_CAPTURE_SYS      = 8'hab;

   // Reset values and the counter all-ones value
   localparam logic [7:0] RST_BYTE             = 8'h00;
   localparam logic [15:0] RST_WORD            = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES      = 16'hffff;

   // Field positions: overflow mask and prescale register
   localparam int POS_OVF_IRQ_EN   = 7;
   localparam int POS_PULLUP_EN    = 5;
   localparam int POS_DRIVE_REDUCE = 4;
   localparam int POS_CNT_RESET_7  = 3;
   localparam int POS_PRESCALE_LO  = 0;
   localparam int PRESCALE_W       = 3;
   // Field positions: system control and overflow flag registers
   localparam int POS_TIMER_EN     = 7;
   localparam int POS_FAST_CLEAR   = 4;
   localparam int POS_OVF_FLAG     = 7;
   // Field positions: capture system register
   localparam int POS_FLAG_MODE    = 3;

   // Output action encoding
   localparam logic [1:0] ACT_DISCONNECT = 2'b00;
   localparam logic [1:0] ACT_TOGGLE     = 2'b01;
   localparam logic [1:0] ACT_LOW        = 2'b10;
   localparam logic [1:0] ACT_HIGH       = 2'b11;
   // Capture edge encoding
   localparam logic [1:0] EDGE_OFF       = 2'b00;
   localparam logic [1:0] EDGE_RISE      = 2'b01;
   localparam logic [1:0] EDGE_FALL      = 2'b10;
   localparam logic [1:0] EDGE_ANY       = 2'b11;

   // Capture pair tracking for the two-capture interrupt mode
   typedef enum logic [0:0] {CCC_PAIR_EMPTY, CCC_PAIR_ONE} ccc_pair_t;

   // Pin control bundle towards the port pads
   typedef struct packed {
      logic [7:0] out_level;
      logic [7:0] out_en;
      logic [7:0] pullup_en;
      logic       drive_reduce;
   } ccc_pin_t;
endpackage : ccc_pkg

// ### ccc_channel_ctrl.sv
// Capture/compare channel control logic
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - Compare match applies action: disconnect, toggle, low, high.
// RULE2 - Software picks compare, action 00, ch7 mask clear for accumulators.
// RULE3 - Edge field per channel: off, rising only, falling only, both edges.
// RULE4 - Channel interrupt mask bit gates each channel flag onto the interrupt.
// RULE5 - Overflow interrupt requested while overflow flag set and its enable set.
// RULE6 - Pull-up enable turns on pull-ups of timer pins used as inputs.
// RULE7 - Drive reduce bit selects reduced output drive on timer pins.
// RULE8 - Counter reset enable makes a channel-7 compare reset counter to zero.
// RULE9 - With reset enabled and ch7 value zero the counter stays at zero.
// RULE10 - Compare reset from all ones to zero does not set overflow flag.
// RULE11 - Three-bit prescale select divides module clock by one up to 128.
// RULE12 - New prescale takes effect when prescale counter is zero.
// RULE13 - Writing one clears a channel flag, zero leaves it, reads have no effect.
// RULE14 - Fast clear: capture read or compare write of channel register clears flag.
// RULE15 - Writing one to overflow flag bit clears it; reads allowed any time.
// RULE16 - Fast clear: any counter access clears the overflow flag register.
// RULE17 - Flag mode with overwrite control raises channel flag after two captures.
// RULE18 - Overflow flag set when the 16-bit counter rolls from all ones to zero.
// RULE19 - Mode bit set makes a channel compare; cleared makes it capture.
// RULE20 - Set ch7 mask bit overrides the channel output action on its pin.
// RULE21 - A flag event in the clearing cycle leaves the flag set.
module ccc_channel_ctrl
   import ccc_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic [7:0]        pin_in,
   input  wire logic [7:0]        compare_match,
   output ccc_pin_t               pin_ctrl,
   output logic [15:0]            main_counter,
   output logic [7:0]             capture_event,
   output logic                   count_tick,
   output logic                   irq
);

   // Software-visible control state, then internal pin, prescale and pair state
   logic [7:0]  channel_mode_select;
   logic [7:0]  ch7_compare_mask;
   logic [7:0]  ch7_mask_data;
   logic [7:0]  sys_ctrl;
   logic [15:0] out_action_ctrl;
   logic [15:0] capture_edge_ctrl;
   logic [7:0]  channel_irq_enables;
   logic [7:0]  overflow_mask_and_prescale;
   logic [7:0]  channel_flag;
   logic        counter_overflow_flag;
   logic [7:0]  capture_overwrite_ctrl;
   logic [7:0]  capture_sys;
   logic [15:0] ch7_compare_value;
   logic [7:0]  compare_output_line;
   logic [7:0]  pin_prev;
   logic [6:0]  prescale_cnt;
   logic [PRESCALE_W-1:0] prescale_active;
   ccc_pair_t   pair_state [8];

   logic        timer_en;
   logic        fast_flag_clear;
   logic        flag_mode_bit;
   logic        wr_hit_flags;
   logic        rd_chan;
   logic        wr_chan;
   logic [2:0]  chan_idx;
   logic        count_access;
   logic        ch7_hit;
   logic [7:0]  compare_hit;
   logic [7:0]  flag_set;
   logic [7:0]  flag_clr;
   logic [7:0]  next_channel_flag;
   logic        ovf_set;
   logic        ovf_clr;
   logic [15:0] next_counter;

   // Field picks from a packed pair of control bytes
   function automatic logic [1:0] pair_field(input logic [15:0] regs, input int n);
      pair_field = regs[2*n +: 2];
   endfunction : pair_field

   // Byte address decode for the channel value window
   function automatic logic in_chan_window(input logic [7:0] a);
      in_chan_window = (a >= OFF_CHAN_BASE) && (a <= OFF_CHAN_LAST);
   endfunction : in_chan_window

   // Decoded control bits
   assign timer_en        = sys_ctrl[POS_TIMER_EN];
   assign fast_flag_clear = sys_ctrl[POS_FAST_CLEAR];
   assign flag_mode_bit   = capture_sys[POS_FLAG_MODE];
   assign wr_hit_flags    = reg_wr && (reg_addr == OFF_CH_FLAGS);
   assign rd_chan         = reg_rd && in_chan_window(reg_addr);
   assign wr_chan         = reg_wr && in_chan_window(reg_addr);
   assign chan_idx        = reg_addr[3:1];
   assign count_access    = (reg_rd || reg_wr) && ((reg_addr == OFF_COUNT_HI) || (reg_addr == OFF_COUNT_LO));

   // Register writes; flags handled with their set logic
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         channel_mode_select        <= RST_BYTE;
         ch7_compare_mask           <= RST_BYTE;
         ch7_mask_data              <= RST_BYTE;
         sys_ctrl                   <= RST_BYTE;
         out_action_ctrl            <= RST_WORD;
         capture_edge_ctrl          <= RST_WORD;
         channel_irq_enables        <= RST_BYTE;
         overflow_mask_and_prescale <= RST_BYTE;
         capture_overwrite_ctrl     <= RST_BYTE;
         capture_sys                <= RST_BYTE;
         ch7_compare_value          <= RST_WORD;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            OFF_CHANNEL_MODE:     channel_mode_select <= reg_wdata;
            OFF_CH7_MASK:         ch7_compare_mask <= reg_wdata;
            OFF_CH7_DATA:         ch7_mask_data <= reg_wdata;
            OFF_SYS_CTRL:         sys_ctrl <= reg_wdata;
            OFF_OUT_ACTION_UPPER: out_action_ctrl[15:8] <= reg_wdata;
            OFF_OUT_ACTION_LOWER: out_action_ctrl[7:0] <= reg_wdata;
            OFF_EDGE_UPPER:       capture_edge_ctrl[15:8] <= reg_wdata;
            OFF_EDGE_LOWER:       capture_edge_ctrl[7:0] <= reg_wdata;
            OFF_CH_IRQ_MASK:      channel_irq_enables <= reg_wdata;
            OFF_OVF_MASK_PRE:     overflow_mask_and_prescale <= reg_wdata;
            OFF_OVERWRITE_CTRL:   capture_overwrite_ctrl <= reg_wdata;
            OFF_CAPTURE_SYS:      capture_sys <= reg_wdata;
            // Only the channel-7 value is kept here, for the counter reset
            8'h9e:                ch7_compare_value[15:8] <= reg_wdata;
            8'h9f:                ch7_compare_value[7:0] <= reg_wdata;
            default:              ;
         endcase
      end
   end

   // Prescale divider; a new selection waits until every stage is zero
   // RULE11 free-running stage counter
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         prescale_cnt <= 7'h00;
      else if (timer_en)
         prescale_cnt <= prescale_cnt + 7'h01;
   end

   // RULE12 adopt selection at zero
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         prescale_active <= 3'h0;
      else if (prescale_cnt == 7'h00)
         prescale_active <= overflow_mask_and_prescale[POS_PRESCALE_LO +: PRESCALE_W];
   end

   // RULE11 tick when the low stages wrap
   always_comb
   begin
      count_tick = 1'b0;
      if (timer_en)
      begin
         case (prescale_active)
            3'h0:    count_tick = 1'b1;
            default: count_tick = ((prescale_cnt & ((7'h01 << prescale_active) - 7'h01)) == 7'h00);
         endcase
      end
   end

   // Channel 7 compare only counts on a compare channel
   // RULE19 compare mode gates matches
   assign compare_hit = compare_match & channel_mode_select;
   assign ch7_hit     = compare_hit[7];

   // Main counter with optional modulus reset
   always_comb
   begin
      next_counter = main_counter;
      ovf_set      = 1'b0;
      if (count_tick)
      begin
         // RULE8 modulus reset
         // RULE9 zero compare holds zero
         if (overflow_mask_and_prescale[POS_CNT_RESET_7]
             && (ch7_hit || (main_counter == ch7_compare_value)))
            next_counter = RST_WORD;
         else
         begin
            next_counter = main_counter + 16'h0001;
            // RULE18 wrap sets overflow
            // RULE10 reset path skips this
            ovf_set = (main_counter == COUNT_ALL_ONES);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         main_counter <= RST_WORD;
      else
         main_counter <= next_counter;
   end

   // Edge detect; pins are synchronous already
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         pin_prev <= RST_BYTE;
      else
         pin_prev <= pin_in;
   end

   // RULE3 edge selection per channel
   always_comb
   begin
      for (int n = 0; n < 8; n++)
      begin
         case (pair_field(capture_edge_ctrl, n))
            EDGE_RISE: capture_event[n] = pin_in[n] && !pin_prev[n];
            EDGE_FALL: capture_event[n] = !pin_in[n] && pin_prev[n];
            EDGE_ANY:  capture_event[n] = pin_in[n] ^ pin_prev[n];
            default:   capture_event[n] = 1'b0;
         endcase
         // RULE19 capture only on capture channels
         capture_event[n] = capture_event[n] && !channel_mode_select[n];
      end
   end

   // Pair tracking for two-capture flag mode
   always_ff @(posedge ref_clk)
   begin
      for (int n = 0; n < 8; n++)
      begin
         if (!rst_b)
            pair_state[n] <= CCC_PAIR_EMPTY;
         else if (capture_event[n])
         begin
            case (pair_state[n])
               CCC_PAIR_EMPTY: pair_state[n] <= CCC_PAIR_ONE;
               CCC_PAIR_ONE:   pair_state[n] <= CCC_PAIR_EMPTY;
               default:        pair_state[n] <= CCC_PAIR_EMPTY;
            endcase
         end
      end
   end

   // Channel flag sources and clears
   always_comb
   begin
      for (int n = 0; n < 8; n++)
      begin
         // RULE17 second capture flags in pair mode
         if (flag_mode_bit && capture_overwrite_ctrl[n])
            flag_set[n] = capture_event[n] && (pair_state[n] == CCC_PAIR_ONE);
         else
            flag_set[n] = capture_event[n];
         flag_set[n] = flag_set[n] || compare_hit[n];
         // RULE13 write one clears
         flag_clr[n] = wr_hit_flags && reg_wdata[n];
         // RULE14 fast clear by channel access
         if (fast_flag_clear && (chan_idx == 3'(n)))
            flag_clr[n] = flag_clr[n] || (rd_chan && !channel_mode_select[n])
                          || (wr_chan && channel_mode_select[n]);
      end
      // RULE21 set beats clear
      next_channel_flag = (channel_flag & ~flag_clr) | flag_set;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         channel_flag <= RST_BYTE;
      else
         channel_flag <= next_channel_flag;
   end

   // Overflow flag clears
   // RULE15 write one clears
   // RULE16 counter access clears
   assign ovf_clr = (reg_wr && (reg_addr == OFF_OVF_FLAGS) && reg_wdata[POS_OVF_FLAG])
                    || (fast_flag_clear && count_access);

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         counter_overflow_flag <= 1'b0;
      // RULE21 set beats clear
      else if (ovf_set)
         counter_overflow_flag <= 1'b1;
      else if (ovf_clr)
         counter_overflow_flag <= 1'b0;
   end

   // Pin action on compare; ch7 mask data overrides
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         compare_output_line <= RST_BYTE;
      else
      begin
         for (int n = 0; n < 8; n++)
         begin
            // RULE20 mask overrides action
            if (ch7_hit && ch7_compare_mask[n])
               compare_output_line[n] <= ch7_mask_data[n];
            else if (compare_hit[n])
            begin
               // RULE1 output action decode
               case (pair_field(out_action_ctrl, n))
                  ACT_TOGGLE: compare_output_line[n] <= !compare_output_line[n];
                  ACT_LOW:    compare_output_line[n] <= 1'b0;
                  ACT_HIGH:   compare_output_line[n] <= 1'b1;
                  default:    ;
               endcase
            end
         end
      end
   end

   // Pad control; action 00, mask clear leaves pin free
   always_comb
   begin
      pin_ctrl.out_level = compare_output_line;
      for (int n = 0; n < 8; n++)
      begin
         // RULE2 disconnected pin stays free
         pin_ctrl.out_en[n] = channel_mode_select[n]
                              && ((pair_field(out_action_ctrl, n) != ACT_DISCONNECT) || ch7_compare_mask[n]);
      end
      // RULE6 pull-ups on input pins only
      pin_ctrl.pullup_en = overflow_mask_and_prescale[POS_PULLUP_EN] ? ~pin_ctrl.out_en : 8'h00;
      // RULE7 drive reduction
      pin_ctrl.drive_reduce = overflow_mask_and_prescale[POS_DRIVE_REDUCE];
   end

   // Interrupt request from masked flags
   // RULE4 channel mask gating
   // RULE5 overflow enable gating
   assign irq = |(channel_flag & channel_irq_enables)
                || (counter_overflow_flag && overflow_mask_and_prescale[POS_OVF_IRQ_EN]);

   // Read data one cycle after the strobe; reads never clear flags except fast clear
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         reg_rdata <= RST_BYTE;
      else if (reg_rd)
      begin
         case (reg_addr)
            OFF_CHANNEL_MODE:     reg_rdata <= channel_mode_select;
            OFF_CH7_MASK:         reg_rdata <= ch7_compare_mask;
            OFF_CH7_DATA:         reg_rdata <= ch7_mask_data;
            OFF_COUNT_HI:         reg_rdata <= main_counter[15:8];
            OFF_COUNT_LO:         reg_rdata <= main_counter[7:0];
            OFF_SYS_CTRL:         reg_rdata <= sys_ctrl;
            OFF_OUT_ACTION_UPPER: reg_rdata <= out_action_ctrl[15:8];
            OFF_OUT_ACTION_LOWER: reg_rdata <= out_action_ctrl[7:0];
            OFF_EDGE_UPPER:       reg_rdata <= capture_edge_ctrl[15:8];
            OFF_EDGE_LOWER:       reg_rdata <= capture_edge_ctrl[7:0];
            OFF_CH_IRQ_MASK:      reg_rdata <= channel_irq_enables;
            OFF_OVF_MASK_PRE:     reg_rdata <= overflow_mask_and_prescale;
            OFF_CH_FLAGS:         reg_rdata <= channel_flag;
            OFF_OVF_FLAGS:        reg_rdata <= {counter_overflow_flag, 7'h00};
            OFF_OVERWRITE_CTRL:   reg_rdata <= capture_overwrite_ctrl;
            OFF_CAPTURE_SYS:      reg_rdata <= capture_sys;
            default:              reg_rdata <= RST_BYTE;
         endcase
      end
      else
         reg_rdata <= RST_BYTE;
   end

endmodule : ccc_channel_ctrl
`default_nettype wire

// ### ccc_properties.sv
// Checker: properties of the channel control block
`timescale 1ns/1ps
`default_nettype none
module ccc_properties
   import ccc_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic [7:0]        pin_in,
   input wire logic [7:0]        compare_match,
   input wire ccc_pin_t          pin_ctrl,
   input wire logic [15:0]       main_counter,
   input wire logic [7:0]        capture_event,
   input wire logic              count_tick,
   input wire logic              irq
);
   logic [7:0]  sh [16];
   logic [15:0] act;
   logic [15:0] edg;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // Shadow of control writes
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         sh <= '{default: 8'h00};
      else if (reg_wr && reg_addr[7:4] == 4'h8)
         sh[reg_addr[3:0]] <= reg_wdata;
   end
   // Action and edge fields, ch0 low
   assign act = {sh[8], sh[9]};
   assign edg = {sh[10], sh[11]};
   sequence s_free_tick;
      count_tick && !sh[13][POS_CNT_RESET_7];
   endsequence
   sequence s_mod_hit;
      count_tick && sh[13][POS_CNT_RESET_7] && compare_match[7] && sh[0][7];
   endsequence
   drive_red_a: assert property (
      pin_ctrl.drive_reduce == sh[13][POS_DRIVE_REDUCE])
      else $error("drive reduce wrong");
   pullup_in_a: assert property (
      (pin_ctrl.pullup_en & (pin_ctrl.out_en | {8{!sh[13][POS_PULLUP_EN]}})) == 8'h00)
      else $error("bad pull-up");
   tick_gate_a: assert property (!sh[6][POS_TIMER_EN] |-> !count_tick)
      else $error("tick while off");
   count_step_a: assert property (
      s_free_tick |=> main_counter == $past(main_counter) + 16'h0001)
      else $error("counter step wrong");
   modulus_a: assert property (s_mod_hit |=> main_counter == 16'h0000)
      else $error("no modulus reset");
   // Per-channel pin and edge checks
   for (genvar i = 0; i < 8; i++)
   begin : g_ch
      disconnect_a: assert property (
         !sh[2][i] && act[2*i+:2] == ACT_DISCONNECT |-> !pin_ctrl.out_en[i])
         else $error("disconnected pin driven");
      level_a: assert property (
         compare_match[i] && sh[0][i] && !sh[2][i] && act[2*i+1]
         |=> pin_ctrl.out_level[i] == $past(act[2*i]))
         else $error("level action wrong");
      toggle_a: assert property (
         compare_match[i] && sh[0][i] && !sh[2][i] && act[2*i+:2] == ACT_TOGGLE
         |=> pin_ctrl.out_level[i] != $past(pin_ctrl.out_level[i]))
         else $error("toggle missing");
      override_a: assert property (
         compare_match[7] && sh[0][7] && sh[0][i] && sh[2][i]
         |=> pin_ctrl.out_level[i] == $past(sh[3][i]))
         else $error("override missing");
      capture_a: assert property (
         !sh[0][i] |-> capture_event[i] == ((edg[2*i] && pin_in[i] && !$past(pin_in[i]))
         || (edg[2*i+1] && !pin_in[i] && $past(pin_in[i]))))
         else $error("capture event wrong");
   end
endmodule : ccc_properties
bind ccc_channel_ctrl ccc_properties u_props (
   .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
   .compare_match(compare_match), .pin_ctrl(pin_ctrl), .main_counter(main_counter),
   .capture_event(capture_event), .count_tick(count_tick), .irq(irq)
);
`default_nettype wire

// ### ccc_pin_model.sv
// Partner model: timer pads and comparators
`timescale 1ns/1ps
`default_nettype none
module ccc_pin_model
   import ccc_pkg::*;
(
   input  wire ccc_pin_t   pin_ctrl,
   input  wire logic [7:0] ext_level,
   input  wire logic [7:0] match_req,
   output logic [7:0]      pin_in,
   output logic [7:0]      compare_match
);
   assign pin_in = (pin_ctrl.out_en & pin_ctrl.out_level) | (~pin_ctrl.out_en & ext_level);
   assign compare_match = match_req;
endmodule : ccc_pin_model
`default_nettype wire

// ### ccc_channel_ctrl_tb.sv
// Testbench of the channel control block
`timescale 1ns/1ps
`default_nettype none
module ccc_channel_ctrl_tb
   import ccc_pkg::*;
;
   logic        ref_clk = 1'h0;
   logic        rst_b = 1'h0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'h0;
   logic        reg_rd = 1'h0;
   logic [7:0]  reg_rdata;
   logic [7:0]  pin_in;
   logic [7:0]  compare_match;
   logic [7:0]  ext_level = 8'h00;
   logic [7:0]  match_req = 8'h00;
   ccc_pin_t    pin_ctrl;
   logic [15:0] main_counter;
   logic [7:0]  capture_event;
   logic        count_tick;
   logic        irq;
   logic [15:0] mx;
   logic [7:0]  rz [4] = '{8'h8a, 8'h8b, 8'h8d, 8'h8e};
   logic [7:0]  rw [3] = '{8'h8a, 8'h8b, 8'h8c};
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          n;
   ccc_channel_ctrl uut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .compare_match(compare_match), .pin_ctrl(pin_ctrl),
      .main_counter(main_counter), .capture_event(capture_event),
      .count_tick(count_tick), .irq(irq));
   ccc_pin_model u_pins (.pin_ctrl(pin_ctrl), .ext_level(ext_level),
      .match_req(match_req), .pin_in(pin_in), .compare_match(compare_match));
   // 200 MHz clock
   always #2.5 ref_clk = ~ref_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One strobe cycle, then a gap
   task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      bus(a, 8'h00, 1'h0);
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask : rd
   task automatic pulse(input logic [7:0] m);
      @(posedge ref_clk);
      match_req <= m;
      @(posedge ref_clk);
      match_req <= 8'h00;
      #1;
   endtask : pulse
   // Cycles up to the next prescaler tick, bounded
   task automatic gap(output int c);
      c = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         c++;
      end
      while (count_tick !== 1'h1 && c < 300);
   endtask : gap
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   // Cycle ceiling; overflow wait is ~65536
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   // Main sequence
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'h1;
      foreach (rz[k])
         rd(rz[k], RST_BYTE);
      foreach (rw[k])
      begin
         bus(rw[k], 8'ha5, 1'h1);
         rd(rw[k], 8'ha5);
         bus(rw[k], 8'h00, 1'h1);
      end
      bus(8'hc0, 8'hff, 1'h1);
      rd(8'hc0, 8'h00);
      bus(OFF_OVF_MASK_PRE, 8'h30, 1'h1);
      #1;
      chk({15'h0, pin_ctrl.drive_reduce}, 16'h0001);
      chk({8'h00, pin_ctrl.pullup_en}, 16'h00ff);
      bus(OFF_OVF_MASK_PRE, 8'h00, 1'h1);
      #1;
      chk({15'h0, pin_ctrl.drive_reduce}, 16'h0000);
      chk({8'h00, pin_ctrl.pullup_en}, 16'h0000);
      $display("registers done");
      // Compare actions, then ch7 override
      bus(OFF_CHANNEL_MODE, 8'hff, 1'h1);
      bus(OFF_OUT_ACTION_LOWER, 8'h39, 1'h1);
      pulse(8'h0f);
      chk({12'h000, pin_ctrl.out_level[3:0]}, 16'h0005);
      chk({8'h00, pin_ctrl.out_en}, 16'h0007);
      pulse(8'h0f);
      chk({12'h000, pin_ctrl.out_level[3:0]}, 16'h0004);
      rd(OFF_CH_FLAGS, 8'h0f);
      bus(OFF_CH_FLAGS, 8'h01, 1'h1);
      rd(OFF_CH_FLAGS, 8'h0e);
      bus(OFF_CH_FLAGS, 8'h00, 1'h1);
      rd(OFF_CH_FLAGS, 8'h0e);
      bus(OFF_CH7_MASK, 8'h02, 1'h1);
      bus(OFF_CH7_DATA, 8'h02, 1'h1);
      pulse(8'h82);
      chk({15'h0, pin_ctrl.out_level[1]}, 16'h0001);
      bus(OFF_CH7_MASK, 8'h00, 1'h1);
      bus(OFF_CH_FLAGS, 8'hff, 1'h1);
      $display("compare done");
      // Capture, irq mask, fast clear
      bus(OFF_CHANNEL_MODE, 8'h00, 1'h1);
      bus(OFF_EDGE_LOWER, 8'h39, 1'h1);
      bus(OFF_CH_FLAGS, 8'hff, 1'h1);
      @(posedge ref_clk);
      ext_level <= 8'h0f;
      rd(OFF_CH_FLAGS, 8'h05);
      bus(OFF_CH_FLAGS, 8'hff, 1'h1);
      @(posedge ref_clk);
      ext_level <= 8'h00;
      rd(OFF_CH_FLAGS, 8'h06);
      bus(OFF_CH_IRQ_MASK, 8'h02, 1'h1);
      #1;
      chk({15'h0, irq}, 16'h0001);
      bus(OFF_CH_IRQ_MASK, 8'h01, 1'h1);
      #1;
      chk({15'h0, irq}, 16'h0000);
      bus(OFF_SYS_CTRL, 8'h10, 1'h1);
      bus(8'h92, 8'h00, 1'h0);
      bus(8'h94, 8'h00, 1'h1);
      rd(OFF_CH_FLAGS, 8'h04);
      bus(OFF_SYS_CTRL, 8'h00, 1'h1);
      bus(OFF_CH_IRQ_MASK, 8'h00, 1'h1);
      bus(8'haa, 8'h04, 1'h1);
      bus(8'hab, 8'h08, 1'h1);
      bus(OFF_CH_FLAGS, 8'hff, 1'h1);
      ext_level <= 8'h04;
      rd(OFF_CH_FLAGS, 8'h00);
      ext_level <= 8'h00;
      rd(OFF_CH_FLAGS, 8'h04);
      $display("capture done");
      // Every prescale code, after adoption
      bus(OFF_SYS_CTRL, 8'h80, 1'h1);
      for (int c = 0; c < 8; c++)
      begin
         bus(OFF_OVF_MASK_PRE, 8'(c), 1'h1);
         repeat (130) @(posedge ref_clk);
         gap(n);
         gap(n);
         chk(16'(n), 16'(1 << c));
      end
      bus(OFF_OVF_MASK_PRE, 8'h00, 1'h1);
      $display("prescale done");
      // Ch7 reset: zero holds, then modulus 0x10
      bus(OFF_CHANNEL_MODE, 8'h80, 1'h1);
      bus(OFF_OVF_MASK_PRE, 8'h08, 1'h1);
      repeat (200) @(posedge ref_clk);
      pulse(8'h80);
      repeat (20) @(posedge ref_clk);
      #1;
      chk(main_counter, 16'h0000);
      bus(8'h9e, 8'h00, 1'h1);
      bus(8'h9f, 8'h10, 1'h1);
      mx = 16'h0000;
      repeat (40)
      begin
         @(posedge ref_clk);
         #1;
         if (main_counter > mx)
            mx = main_counter;
      end
      chk(mx, 16'h0010);
      $display("modulus done");
      // Wrap sets overflow; irq and clearing
      bus(OFF_OVF_MASK_PRE, 8'h80, 1'h1);
      n = 0;
      while (main_counter !== COUNT_ALL_ONES && n < 70000)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      repeat (3) @(posedge ref_clk);
      rd(OFF_OVF_FLAGS, 8'h80);
      chk({15'h0, irq}, 16'h0001);
      bus(OFF_OVF_MASK_PRE, 8'h00, 1'h1);
      #1;
      chk({15'h0, irq}, 16'h0000);
      bus(OFF_OVF_FLAGS, 8'h00, 1'h1);
      rd(OFF_OVF_FLAGS, 8'h80);
      bus(OFF_SYS_CTRL, 8'h90, 1'h1);
      bus(OFF_COUNT_HI, 8'h00, 1'h0);
      rd(OFF_OVF_FLAGS, 8'h00);
      $display("overflow done");
      final_report();
   end
endmodule : ccc_channel_ctrl_tb
`default_nettype wire
